/* rtl/scan_port_defines.vh */
// scan_port_defines.vh: constants of the scan access port.
// assumes inclusion by bare name from the rtl files.
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH
// controller states
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SHIFT_IR   4'hB
`define ST_EXIT1_IR   4'hC
`define ST_PAUSE_IR   4'hD
`define ST_EXIT2_IR   4'hE
`define ST_UPD_IR     4'hF
// instruction codes
`define OP_EXTEST     3'h0
`define OP_IDCODE     3'h1
`define OP_SAMPLE     3'h2
`define OP_CLAMP      3'h3
`define OP_HIGHZ      3'h4
`define OP_BYPASS     3'h7
// fixed capture pattern for the instruction shift stage
`define IR_CAPTURE    3'h1
// widths
`define IR_W          3
`define ID_W          32
`endif

/* rtl/pin_sync.v */
// pin_sync.v: two-flop synchroniser for one asynchronous level.
// assumes the level may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire clk,
  input  wire rst,
  input  wire async_in,
  output reg  sync_out
);
  reg meta_q;  // first stage, read only by the second
  // plain double register
  always @(posedge clk) begin
    if (rst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* rtl/tap_fsm.v */
// tap_fsm.v: sixteen-state controller of the scan access port.
// assumes step is a one-cycle pulse at each test clock rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defines.vh"
module tap_fsm (
  input  wire       clk,
  input  wire       rst,
  input  wire       step,
  input  wire       tms,
  output reg  [3:0] state_q
);
  reg [3:0] state_d;  // next state
  // next-state decode, taken only at a test clock rise
  always @* begin
    case (state_q)
      `ST_RESET:    state_d = tms ? `ST_RESET    : `ST_IDLE;
      `ST_IDLE:     state_d = tms ? `ST_SEL_DR   : `ST_IDLE;
      `ST_SEL_DR:   state_d = tms ? `ST_SEL_IR   : `ST_CAP_DR;
      `ST_CAP_DR:   state_d = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_SHIFT_DR: state_d = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_EXIT1_DR: state_d = tms ? `ST_UPD_DR   : `ST_PAUSE_DR;
      `ST_PAUSE_DR: state_d = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
      `ST_EXIT2_DR: state_d = tms ? `ST_UPD_DR   : `ST_SHIFT_DR;
      `ST_UPD_DR:   state_d = tms ? `ST_SEL_DR   : `ST_IDLE;
      `ST_SEL_IR:   state_d = tms ? `ST_RESET    : `ST_CAP_IR;
      `ST_CAP_IR:   state_d = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_SHIFT_IR: state_d = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_EXIT1_IR: state_d = tms ? `ST_UPD_IR   : `ST_PAUSE_IR;
      `ST_PAUSE_IR: state_d = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
      `ST_EXIT2_IR: state_d = tms ? `ST_UPD_IR   : `ST_SHIFT_IR;
      `ST_UPD_IR:   state_d = tms ? `ST_SEL_DR   : `ST_IDLE;
      default:      state_d = `ST_RESET;
    endcase
  end
  // state register: moves only at a rising test clock edge
  always @(posedge clk) begin
    if (rst) begin
      state_q <= `ST_RESET;
    end else if (step) begin
      state_q <= state_d;
    end
  end
endmodule // tap_fsm
`default_nettype wire

/* rtl/scan_port.v */
// scan_port.v: boundary-scan test access port, top level.
// assumes test pins are asynchronous to MCLK and the test clock is
// much slower than MCLK (at least four MCLK periods per phase).
// Notes on behaviour
// - power-up in reset state, instruction identify
// - states move on test clock rise only
// - select-data holds registers, branches on mode
// - capture-data loads selected register, then branch
// - shift-data moves selected register toward output
// - exit1-data goes to update or pause
// - pause-data holds; exit2 to update or shift
// - update-data latches outputs on falling edge
// - select-instruction branches to capture or reset
// - capture-instruction loads fixed value
// - shift-instruction shifts instruction stage
// - exit1-instruction goes to pause or update
// - pause-instruction holds; exit2 update or shift
// - instruction latched on falling edge into update
// - boundary codes 010, 000; identify 001
// - bypass codes 111, 011, 100
// - sample captures pins, shift loads boundary register
// - extest drives pins from boundary outputs
// - bypass is one stage from input to output
// - identify loads code at capture, shifts out
// - highz floats outputs; clamp holds boundary outputs
// - identify register 32 bits, selected in reset
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_port #(
  parameter BSR_W   = 8,            // boundary cells, one per pin
  parameter ID_CODE = 32'h0000_0001 // arbitrary value, bit 0 set
) (
  input  wire             MCLK,
  input  wire             SYS_RST,
  input  wire             TEST_CLOCK_IN,
  input  wire             TEST_RESET_N,
  input  wire             TEST_MODE_SELECT,
  input  wire             TEST_SERIAL_IN,
  output reg              TEST_SERIAL_OUT,
  output reg              TEST_SERIAL_OUT_OE_N,
  input  wire [BSR_W-1:0] PIN_IN,
  input  wire [BSR_W-1:0] CORE_OUT,
  output reg  [BSR_W-1:0] PIN_OUT,
  output reg              PIN_OE_N,
  output wire [2:0]       CURRENT_INSTR
);
  // synchronised pin levels
  wire tck_s;       // test clock after two flops
  wire trst_n_s;    // test reset after two flops
  wire tms_s;       // mode select after two flops
  wire tdi_s;       // serial input after two flops
  reg  tck_q;       // previous test clock level, edge finder
  wire tck_rise;    // one-cycle pulse per rising edge
  wire tck_fall;    // one-cycle pulse per falling edge
  wire rst_all;     // system or test reset
  wire [3:0] state; // controller state

  // shift and latch stages
  reg  [`IR_W-1:0] ir_shift_q;  // instruction shift stage
  reg  [`IR_W-1:0] ir_q;        // current instruction
  reg  [`ID_W-1:0] id_shift_q;  // identification shift stage
  reg  [`ID_W-1:0] id_latch_q;  // identification latched output
  reg  [BSR_W-1:0] bsr_shift_q; // boundary shift stage
  reg  [BSR_W-1:0] bsr_latch_q; // boundary latched output
  reg              byp_q;       // one-bit bypass stage
  reg  [1:0]       sel_d;       // data register picked now

  localparam SEL_BSR = 2'h0;  // boundary register
  localparam SEL_ID  = 2'h1;  // identification register
  localparam SEL_BYP = 2'h2;  // bypass register

  // pin synchronisers; each test pin input passes two flops first
  pin_sync u_tck (.clk(MCLK), .rst(SYS_RST), .async_in(TEST_CLOCK_IN),
                  .sync_out(tck_s));
  pin_sync u_trst (.clk(MCLK), .rst(SYS_RST), .async_in(TEST_RESET_N),
                   .sync_out(trst_n_s));
  pin_sync u_tms (.clk(MCLK), .rst(SYS_RST), .async_in(TEST_MODE_SELECT),
                  .sync_out(tms_s));
  pin_sync u_tdi (.clk(MCLK), .rst(SYS_RST), .async_in(TEST_SERIAL_IN),
                  .sync_out(tdi_s));

  // test reset is sampled like any pin; its effect is immediate
  // on the next MCLK edge, which is asynchronous to the test clock
  assign rst_all = SYS_RST | ~trst_n_s;

  // edge finder on the synchronised test clock
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_q;
  assign tck_fall = ~tck_s & tck_q;

  // controller
  tap_fsm u_fsm (
    .clk     (MCLK),
    .rst     (rst_all),
    .step    (tck_rise),
    .tms     (tms_s),
    .state_q (state)
  );

  // instruction decode, used by the data path and the output mux
  function [1:0] pick_reg;
    input [2:0] op;
    begin
      case (op)
        `OP_SAMPLE, `OP_EXTEST: pick_reg = SEL_BSR;
        `OP_IDCODE:             pick_reg = SEL_ID;
        default:                pick_reg = SEL_BYP;
      endcase
    end
  endfunction

  // identification register is also selected in the reset state
  always @* begin
    if (state == `ST_RESET) begin
      sel_d = SEL_ID;
    end else begin
      sel_d = pick_reg(ir_q);
    end
  end

  assign CURRENT_INSTR = ir_q;

  // instruction shift stage, moves on test clock rise
  always @(posedge MCLK) begin
    if (rst_all) begin
      ir_shift_q <= `IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == `ST_CAP_IR) begin
        ir_shift_q <= `IR_CAPTURE;
      end else if (state == `ST_SHIFT_IR) begin
        ir_shift_q <= {tdi_s, ir_shift_q[`IR_W-1:1]};
      end
    end
  end

  // current instruction, latched on the falling edge in update
  always @(posedge MCLK) begin
    if (rst_all) begin
      ir_q <= `OP_IDCODE;
    end else if (state == `ST_RESET) begin
      ir_q <= `OP_IDCODE;
    end else if (tck_fall && state == `ST_UPD_IR) begin
      ir_q <= ir_shift_q;
    end
  end

  // data registers: capture and shift on test clock rise
  always @(posedge MCLK) begin
    if (rst_all) begin
      id_shift_q  <= {`ID_W{1'b0}};
      bsr_shift_q <= {BSR_W{1'b0}};
      byp_q       <= 1'b0;
    end else if (tck_rise) begin
      if (state == `ST_CAP_DR) begin
        case (sel_d)
          SEL_ID:  id_shift_q  <= ID_CODE;
          SEL_BSR: bsr_shift_q <= PIN_IN;
          default: byp_q       <= 1'b0;
        endcase
      end else if (state == `ST_SHIFT_DR) begin
        case (sel_d)
          SEL_ID:  id_shift_q  <= {tdi_s, id_shift_q[`ID_W-1:1]};
          SEL_BSR: bsr_shift_q <= {tdi_s, bsr_shift_q[BSR_W-1:1]};
          default: byp_q       <= tdi_s;
        endcase
      end
      // other states hold every stage (pause, exits, selects)
    end
  end

  // latched outputs, copied on the falling edge in update-data
  always @(posedge MCLK) begin
    if (rst_all) begin
      id_latch_q  <= ID_CODE;
      bsr_latch_q <= {BSR_W{1'b0}};
    end else if (tck_fall && state == `ST_UPD_DR) begin
      case (sel_d)
        SEL_ID:  id_latch_q  <= id_shift_q;
        SEL_BSR: bsr_latch_q <= bsr_shift_q;
        default: id_latch_q  <= id_latch_q;
      endcase
    end
  end

  // serial output changes on the falling edge, as scan masters expect
  always @(posedge MCLK) begin
    if (rst_all) begin
      TEST_SERIAL_OUT      <= 1'b0;
      TEST_SERIAL_OUT_OE_N <= 1'b1;
    end else if (tck_fall) begin
      TEST_SERIAL_OUT_OE_N <= ~((state == `ST_SHIFT_DR) || (state == `ST_SHIFT_IR));
      if (state == `ST_SHIFT_IR) begin
        TEST_SERIAL_OUT <= ir_shift_q[0];
      end else begin
        case (sel_d)
          SEL_ID:  TEST_SERIAL_OUT <= id_shift_q[0];
          SEL_BSR: TEST_SERIAL_OUT <= bsr_shift_q[0];
          default: TEST_SERIAL_OUT <= byp_q;
        endcase
      end
    end
  end

  // pin drive: functional path unless a test instruction owns the pins
  // only the system reset clears it; a test reset must not disturb the
  // functional outputs, and identify in reset passes the core through
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      PIN_OUT  <= {BSR_W{1'b0}};
      PIN_OE_N <= 1'b0;
    end else begin
      case (ir_q)
        `OP_EXTEST, `OP_CLAMP: begin
          PIN_OUT  <= bsr_latch_q;
          PIN_OE_N <= 1'b0;
        end
        `OP_HIGHZ: begin
          PIN_OUT  <= bsr_latch_q;
          PIN_OE_N <= 1'b1;
        end
        default: begin
          PIN_OUT  <= CORE_OUT;    // normal operation keeps running
          PIN_OE_N <= 1'b0;
        end
      endcase
    end
  end
endmodule // scan_port
`default_nettype wire

/* bench/scan_port_assertions.sv */
// scan_port_assertions.sv: pin-level timing checks of the scan port.
// assumes test clock phases of at least 12 MCLK.
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_port_assertions #(
  parameter BSR_W = 8
) (
  input wire logic             MCLK,
  input wire logic             SYS_RST,
  input wire logic             TEST_CLOCK_IN,
  input wire logic             TEST_RESET_N,
  input wire logic             TEST_MODE_SELECT,
  input wire logic             TEST_SERIAL_IN,
  input wire logic             TEST_SERIAL_OUT,
  input wire logic             TEST_SERIAL_OUT_OE_N,
  input wire logic [BSR_W-1:0] PIN_IN,
  input wire logic [BSR_W-1:0] CORE_OUT,
  input wire logic [BSR_W-1:0] PIN_OUT,
  input wire logic             PIN_OE_N,
  input wire logic [2:0]       CURRENT_INSTR
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // two samples of one code, so registered pins have caught up
  sequence s_held(logic [2:0] op);
    (CURRENT_INSTR == op)[*2];
  endsequence
  // pins follow the core when no test drive is selected
  property p_pass(logic [2:0] op);
    s_held(op) |-> PIN_OUT == $past(CORE_OUT) && !PIN_OE_N;
  endproperty
  a_reset_values: assert property (disable iff (1'b0) SYS_RST |=> CURRENT_INSTR == `OP_IDCODE
    && TEST_SERIAL_OUT_OE_N && ~|PIN_OUT) else $error("reset values wrong");
  a_test_reset_id: assert property (!TEST_RESET_N [*5] |-> CURRENT_INSTR == `OP_IDCODE)
    else $error("test reset did not select identify");
  a_instr_on_fall: assert property ($changed(CURRENT_INSTR) && CURRENT_INSTR != `OP_IDCODE
    |-> !TEST_CLOCK_IN) else $error("instruction changed with test clock high");
  // serial out moves only in the low phase
  a_tdo_on_fall: assert property (disable iff (SYS_RST || !TEST_RESET_N)
    $changed(TEST_SERIAL_OUT) |-> !TEST_CLOCK_IN) else $error("serial out moved in high phase");
  a_highz_float: assert property (s_held(`OP_HIGHZ) |-> PIN_OE_N)
    else $error("pins driven under highz");
  a_clamp_steady: assert property (s_held(`OP_CLAMP) |-> $stable(PIN_OUT) && !PIN_OE_N)
    else $error("pins moved under clamp");
  a_extest_latch: assert property (s_held(`OP_EXTEST) ##0 TEST_CLOCK_IN
    |-> $stable(PIN_OUT) && !PIN_OE_N) else $error("pins followed shifting");
  a_bypass_pass: assert property (p_pass(`OP_BYPASS)) else $error("bypass disturbed pins");
  a_sample_pass: assert property (p_pass(`OP_SAMPLE)) else $error("sample disturbed pins");
  a_ident_pass: assert property (p_pass(`OP_IDCODE)) else $error("identify disturbed pins");
endmodule // scan_port_assertions
bind scan_port scan_port_assertions #(.BSR_W(BSR_W)) u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .TEST_CLOCK_IN(TEST_CLOCK_IN), .TEST_RESET_N(TEST_RESET_N),
  .TEST_MODE_SELECT(TEST_MODE_SELECT), .TEST_SERIAL_IN(TEST_SERIAL_IN),
  .TEST_SERIAL_OUT(TEST_SERIAL_OUT), .TEST_SERIAL_OUT_OE_N(TEST_SERIAL_OUT_OE_N),
  .PIN_IN(PIN_IN), .CORE_OUT(CORE_OUT), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
  .CURRENT_INSTR(CURRENT_INSTR));
`default_nettype wire

/* bench/scan_master.sv */
// scan_master.sv: behavioural tester on the scan port pins.
// assumes mclk of 5 ns; test clock runs only inside step.
`timescale 1ns/1ps
`default_nettype none
module scan_master (
  input  wire logic mclk,
  input  wire logic tdo,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic bit_val
);
  event got; // a shifted-out bit was taken
  // idle pins: clock parked low, mode high keeps reset state
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    bit_val = 1'b0;
  end
  // one 130 ns period: 14 mclk low, 12 high
  task automatic step(input logic m, input logic d, input logic sh);
    @(negedge mclk);
    tms = m;
    tdi = sh ? d : ~tdi; // unused data toggles so stale bits never pass
    repeat (13) @(negedge mclk);
    if (sh) begin
      bit_val = tdo; // settled long after the fall
      -> got;
    end
    tck = 1'b1;
    repeat (12) @(negedge mclk);
    tck = 1'b0;
  endtask
endmodule // scan_master
`default_nettype wire

/* bench/scan_port_tb.sv */
// scan_port_tb.sv: self-checking bench of the scan access port.
// assumes scan_master drives the test pins; checker bound.
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_port_tb;
  localparam [31:0] ID_VAL = 32'h2B4D_6E1F; // arbitrary value, bit 0 set
  logic        mclk = 1'b0;     // 200 MHz clock
  logic        rst = 1'b1;      // synchronous reset
  logic        trst_n = 1'b1;   // test reset pin
  logic [7:0]  pin_in = 8'h00;  // pin levels for capture
  logic [7:0]  core_out = 8'h00;// functional outputs
  logic [7:0]  latch_v = 8'h00; // boundary output latch model
  logic [31:0] din, xp;         // shifted-in data, expected out
  logic        eq[$];           // expected serial bits, oldest first
  int          failures = 0;
  int          check_count = 0;
  wire         tck, tms, tdi, tdo, oe_n, pin_oe_n, sbit;
  wire  [7:0]  pin_out;
  wire  [2:0]  instr;
  logic [2:0]  ops[6] = '{`OP_SAMPLE, `OP_EXTEST, `OP_CLAMP, `OP_HIGHZ, `OP_BYPASS, `OP_IDCODE};
  always #2.5 mclk = ~mclk;
  scan_port #(.BSR_W(8), .ID_CODE(ID_VAL)) DUT (.MCLK(mclk), .SYS_RST(rst),
    .TEST_CLOCK_IN(tck), .TEST_RESET_N(trst_n), .TEST_MODE_SELECT(tms),
    .TEST_SERIAL_IN(tdi), .TEST_SERIAL_OUT(tdo), .TEST_SERIAL_OUT_OE_N(oe_n),
    .PIN_IN(pin_in), .CORE_OUT(core_out), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .CURRENT_INSTR(instr));
  scan_master m (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .bit_val(sbit));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // each taken serial bit against the oldest note
  always @(m.got) begin
    check(sbit, eq.size() ? eq.pop_front() : 1'bx);
    check(oe_n, 1'b0);
  end
  // idle to idle scan; bit pz detours through pause
  task automatic scan(input bit ir, input int n, input int pz, input logic [31:0] d,
                      input logic [31:0] x);
    m.step(1'b1, 1'b0, 1'b0);
    if (ir)
      m.step(1'b1, 1'b0, 1'b0);
    m.step(1'b0, 1'b0, 1'b0);
    m.step(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      eq.push_back(x[i]);
      m.step(i == n - 1 || i == pz, d[i], 1'b1);
      if (i == pz) begin
        m.step(1'b0, 1'b0, 1'b0);
        m.step(1'b0, 1'b0, 1'b0);
        m.step(1'b1, 1'b0, 1'b0);
        m.step(1'b0, 1'b0, 1'b0);
      end
    end
    m.step(1'b1, 1'b0, 1'b0);
    m.step(1'b0, 1'b0, 1'b0);
    check(oe_n, 1'b1);
  endtask
  // instruction load; capture pattern comes out first
  task automatic ld(input logic [2:0] op, input int pz);
    scan(1'b1, 3, pz, {29'h0, op}, 32'h0000_0001);
    check(instr, op);
  endtask
  // hung handshake guard, well past the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    stop_test;
  end
  initial begin
    din = $urandom(14604);
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    repeat (6) @(negedge mclk);
    check(instr, `OP_IDCODE);
    m.step(1'b0, 1'b0, 1'b0);
    scan(1'b0, 32, 5, din, ID_VAL);
    foreach (ops[k]) begin
      @(negedge mclk);
      {pin_in, core_out} = 16'($urandom);
      din = $urandom;
      ld(ops[k], k == 0 ? 1 : -1);
      case (ops[k])
        `OP_EXTEST, `OP_SAMPLE: xp = {24'h0, pin_in};
        `OP_IDCODE: xp = ID_VAL;
        default: xp = din << 1;
      endcase
      scan(1'b0, 8, -1, din, xp);
      if (ops[k] == `OP_EXTEST || ops[k] == `OP_SAMPLE)
        latch_v = din[7:0];
      if (ops[k] == `OP_HIGHZ)
        check(pin_oe_n, 1'b1);
      else if (ops[k] == `OP_EXTEST || ops[k] == `OP_CLAMP)
        check(pin_out, latch_v);
      else
        check(pin_out, core_out);
    end
    ld(`OP_BYPASS, -1);
    repeat (3) m.step(1'b1, 1'b0, 1'b0);
    check(instr, `OP_IDCODE);
    m.step(1'b0, 1'b0, 1'b0);
    ld(`OP_BYPASS, -1);
    @(negedge mclk) trst_n = 1'b0;
    repeat (6) @(negedge mclk);
    check(instr, `OP_IDCODE);
    trst_n = 1'b1;
    repeat (6) @(negedge mclk);
    m.step(1'b0, 1'b0, 1'b0);
    scan(1'b0, 32, -1, din, ID_VAL);
    ld(`OP_BYPASS, -1);
    @(negedge mclk) rst = 1'b1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    check(instr, `OP_IDCODE);
    m.step(1'b0, 1'b0, 1'b0);
    scan(1'b0, 8, -1, din, ID_VAL);
    stop_test;
  end
endmodule // scan_port_tb
`default_nettype wire
